// ---- logic/gas_bridge_defines.vh ----
// Constants for the gas sensor serial bridge
`ifndef GAS_BRIDGE_DEFINES_VH
`define GAS_BRIDGE_DEFINES_VH
`define CLK_HZ 40000000
`define BAUD_RATE 9600
`define BAUD_DIV 4167
`define DATA_BITS 8
`define SELFTEST_MS 5
`define SELFTEST_CYC 200000
`define ADDR_W 10
`define BASE_ADDR 10'h0300
`define REG_DATA 1'h0
`define REG_CTRL 1'h1
`define ST_RX_READY 0
`define ST_TX_READY 1
`define ST_SENSOR_UP 2
`define ST_TEST_MODE 3
`define ST_RX_OVERRUN 4
`define CTRL_CLR_OVR 4
`endif

// ---- logic/uart_tx.v ----
// Serial transmitter, 8N1, timed by its own DIV-clock bit counter
`timescale 1ns/10ps
module uart_tx #(
   parameter DIV = 4167
) (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_b_i,
   // Byte in
   input wire start_i,
   input wire [7:0] data_i,
   output reg busy_o,
   // Line
   output reg tx_o
);
   reg [12:0] cnt_q;
   reg [3:0] bit_q;
   reg [8:0] sh_q;
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= 13'h0000;
         bit_q <= 4'h0;
         sh_q <= 9'h1ff;
         busy_o <= 1'b0;
         tx_o <= 1'b1;
      end else if (!busy_o) begin
         if (start_i) begin
            busy_o <= 1'b1;
            tx_o <= 1'b0;
            sh_q <= {1'b1, data_i};
            cnt_q <= DIV[12:0] - 13'h0001;
            bit_q <= 4'h0;
         end
      end else if (cnt_q != 13'h0000) begin
         cnt_q <= cnt_q - 13'h0001;
      end else begin
         cnt_q <= DIV[12:0] - 13'h0001;
         if (bit_q == 4'h9) begin
            busy_o <= 1'b0;
            tx_o <= 1'b1;
         end else begin
            tx_o <= sh_q[0];
            sh_q <= {1'b1, sh_q[8:1]};
            bit_q <= bit_q + 4'h1;
         end
      end
   end
endmodule

// ---- logic/uart_rx.v ----
// Serial receiver, 8N1, mid-bit sampling
`timescale 1ns/10ps
module uart_rx #(
   parameter DIV = 4167
) (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_b_i,
   // Line, already synchronised
   input wire rx_i,
   // Byte out
   output reg valid_o,
   output reg [7:0] data_o
);
   reg [12:0] cnt_q;
   reg [3:0] bit_q;
   reg act_q;
   reg [7:0] sh_q;
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= 13'h0000;
         bit_q <= 4'h0;
         act_q <= 1'b0;
         sh_q <= 8'h00;
         valid_o <= 1'b0;
         data_o <= 8'h00;
      end else begin
         valid_o <= 1'b0;
         if (!act_q) begin
            if (!rx_i) begin
               act_q <= 1'b1;
               cnt_q <= DIV[13:1];
               bit_q <= 4'h0;
            end
         end else if (cnt_q != 13'h0000) begin
            cnt_q <= cnt_q - 13'h0001;
         end else begin
            cnt_q <= DIV[12:0] - 13'h0001;
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h0) begin
               // False start: line back high at mid start bit
               if (rx_i) act_q <= 1'b0;
            end else if (bit_q == 4'h9) begin
               act_q <= 1'b0;
               // Frames with a bad stop bit are dropped
               if (rx_i) begin
                  valid_o <= 1'b1;
                  data_o <= sh_q;
               end
            end else begin
               sh_q <= {rx_i, sh_q[7:1]};
            end
         end
      end
   end
endmodule

// ---- logic/gas_bridge_module.v ----
// Host bus to serial gas sensor bridge with sensor reset sequencing
`timescale 1ns/10ps
`include "gas_bridge_defines.vh"
module gas_bridge_module #(
   parameter BASE = `BASE_ADDR,
   parameter BAUD_DIV = `BAUD_DIV,
   parameter SELFTEST_CYC = `SELFTEST_CYC
) (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_b_i,
   // Host bus
   input wire [`ADDR_W-1:0] addr_i,
   input wire cs_b_i,
   input wire wr_b_i,
   input wire rd_b_i,
   input wire [7:0] wdata_i,
   output reg [7:0] rdata_o,
   output reg rdata_oe_o,
   // Sensor link
   input wire sensor_rx_i,
   output reg sensor_tx_o,
   // Sensor reset, open collector
   input wire sensor_rst_b_i,
   output reg sensor_rst_b_o,
   output reg sensor_rst_oe_o,
   // Option jumpers, fitted pulls low
   input wire test_mode_jumper_b_i,
   input wire spare_option_jumper_b_i,
   // Status
   output reg test_mode_o,
   output reg ready_o
);
   localparam S_TEST = 3'b001;
   localparam S_RUN = 3'b010;
   localparam S_DIAG = 3'b100;

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [17:0] st_cnt_q;
   reg [1:0] mem_chk_q;
   reg [2:0] rx_sync_q;
   reg rx_line_q;
   reg [2:0] jp_sync_q;
   reg jp_line_q;
   reg [2:0] bus_sync_q [0:2];
   reg wr_seen_q;
   reg rd_seen_q;
   reg [7:0] tx_hold_q;
   reg tx_full_q;
   reg tx_start_q;
   reg [7:0] rx_hold_q;
   reg rx_full_q;
   reg rx_ovr_q;
   reg [7:0] pattern_q;
   wire tx_busy;
   wire tx_line;
   wire rx_valid;
   wire [7:0] rx_data;
   wire hit;
   wire wr_now;
   wire rd_now;
   wire wr_edge;
   wire rd_edge;
   wire [7:0] status;
   wire link_rx;

   // Bus strobes arrive from another domain: three stages, act when 2nd and 3rd agree
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bus_sync_q[0] <= 3'h7;
         bus_sync_q[1] <= 3'h7;
         bus_sync_q[2] <= 3'h7;
         rx_sync_q <= 3'h7;
         rx_line_q <= 1'b1;
         jp_sync_q <= 3'h7;
         jp_line_q <= 1'b1;
         wr_seen_q <= 1'b0;
         rd_seen_q <= 1'b0;
      end else begin
         bus_sync_q[0] <= {cs_b_i, wr_b_i, rd_b_i};
         bus_sync_q[1] <= bus_sync_q[0];
         bus_sync_q[2] <= bus_sync_q[1];
         rx_sync_q <= {rx_sync_q[1:0], sensor_rx_i};
         if (rx_sync_q[1] == rx_sync_q[2]) rx_line_q <= rx_sync_q[2];
         jp_sync_q <= {jp_sync_q[1:0], test_mode_jumper_b_i};
         if (jp_sync_q[1] == jp_sync_q[2]) jp_line_q <= jp_sync_q[2];
         wr_seen_q <= wr_now;
         rd_seen_q <= rd_now;
      end
   end

   // Address bits are stable for the whole strobe, so they are used directly
   assign hit = (addr_i[`ADDR_W-1:1] == BASE[`ADDR_W-1:1]);
   assign wr_now = hit && (bus_sync_q[1] == bus_sync_q[2]) && !bus_sync_q[2][2] && !bus_sync_q[2][1];
   assign rd_now = hit && (bus_sync_q[1] == bus_sync_q[2]) && !bus_sync_q[2][2] && !bus_sync_q[2][0];
   assign wr_edge = wr_now && !wr_seen_q;
   assign rd_edge = rd_now && !rd_seen_q;
   assign status = {3'h0, rx_ovr_q, test_mode_o, ready_o, !tx_full_q && ready_o, rx_full_q};
   assign link_rx = (state_q == S_DIAG) ? tx_line : rx_line_q;

   always @* begin
      state_d = state_q;
      case (state_q)
         S_TEST: begin
            // Jumper is low when fitted; spare jumper deliberately unused
            if (st_cnt_q == 18'h00000 && mem_chk_q == 2'h3) begin
               state_d = (jp_line_q == 1'b0) ? S_DIAG : S_RUN;
            end
         end
         S_RUN: state_d = S_RUN;
         S_DIAG: state_d = S_DIAG;
         default: state_d = S_TEST;
      endcase
   end

   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= S_TEST;
         st_cnt_q <= 18'h00000;
         mem_chk_q <= 2'h0;
         test_mode_o <= 1'b0;
         ready_o <= 1'b0;
         sensor_rst_b_o <= 1'b0;
         sensor_rst_oe_o <= 1'b1;
         pattern_q <= 8'h55;
      end else begin
         state_q <= state_d;
         if (state_q == S_TEST) begin
            // Counter loads on the first cycle, then checks run while it drains
            if (mem_chk_q == 2'h0) begin
               st_cnt_q <= SELFTEST_CYC[17:0] - 18'h00001;
               mem_chk_q <= 2'h1;
            end else if (st_cnt_q != 18'h00000) begin
               st_cnt_q <= st_cnt_q - 18'h00001;
            end
            // Check that both hold registers read zero stands in for memory checks
            if (mem_chk_q == 2'h1 && tx_hold_q == 8'h00 && rx_hold_q == 8'h00) mem_chk_q <= 2'h3;
         end
         sensor_rst_oe_o <= (state_d == S_TEST);
         sensor_rst_b_o <= 1'b0;
         ready_o <= (state_d == S_RUN);
         test_mode_o <= (state_d == S_DIAG);
         // Start pulse must be seen, or the pattern would flip twice per byte
         if (state_q == S_DIAG && !tx_busy && !tx_full_q && !tx_start_q) pattern_q <= ~pattern_q;
      end
   end

   // Data paths
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_hold_q <= 8'h00;
         tx_full_q <= 1'b0;
         tx_start_q <= 1'b0;
         rx_hold_q <= 8'h00;
         rx_full_q <= 1'b0;
         rx_ovr_q <= 1'b0;
         rdata_o <= 8'h00;
         rdata_oe_o <= 1'b0;
         sensor_tx_o <= 1'b1;
      end else begin
         tx_start_q <= 1'b0;
         sensor_tx_o <= tx_line;
         rdata_oe_o <= rd_now;
         if (state_q == S_RUN) begin
            if (wr_edge && addr_i[0] == `REG_DATA && !tx_full_q) begin
               tx_hold_q <= wdata_i;
               tx_full_q <= 1'b1;
            end else if (tx_full_q && !tx_busy && !tx_start_q) begin
               tx_start_q <= 1'b1;
               tx_full_q <= 1'b0;
            end
            // Byte arriving while the host clears overrun still flags it
            if (rx_valid && rx_full_q && !(rd_edge && addr_i[0] == `REG_DATA)) begin
               rx_ovr_q <= 1'b1;
            end else if (wr_edge && addr_i[0] == `REG_CTRL && wdata_i[`CTRL_CLR_OVR]) begin
               rx_ovr_q <= 1'b0;
            end
            if (rx_valid) begin
               rx_hold_q <= rx_data;
               rx_full_q <= 1'b1;
            end else if (rd_edge && addr_i[0] == `REG_DATA) begin
               rx_full_q <= 1'b0;
            end
         end else if (state_q == S_DIAG) begin
            // Loopback: pattern out, compared against what returns
            if (!tx_busy && !tx_full_q && !tx_start_q) begin
               tx_hold_q <= pattern_q;
               tx_start_q <= 1'b1;
            end
            if (rx_valid) begin
               rx_hold_q <= rx_data;
               rx_full_q <= 1'b1;
               rx_ovr_q <= (rx_data != tx_hold_q);
            end
         end else begin
            tx_hold_q <= 8'h00;
            rx_hold_q <= 8'h00;
         end
         if (rd_now) begin
            rdata_o <= (addr_i[0] == `REG_DATA) ? rx_hold_q : status;
         end
      end
   end

   uart_tx #(
      .DIV(BAUD_DIV)
   ) u_tx (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .start_i(tx_start_q),
      .data_i(tx_hold_q),
      .busy_o(tx_busy),
      .tx_o(tx_line)
   );

   uart_rx #(
      .DIV(BAUD_DIV)
   ) u_rx (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .rx_i(link_rx),
      .valid_o(rx_valid),
      .data_o(rx_data)
   );
endmodule

// ---- testbench/gas_bridge_module_sva.sv ----
// Port checker for the gas sensor bridge
`timescale 1ns/10ps
module bridge_checker (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_b_i,
   // Watched ports
   input wire rd_b_i,
   input wire rdata_oe_o,
   input wire sensor_tx_o,
   input wire sensor_rst_b_o,
   input wire sensor_rst_oe_o,
   input wire test_mode_o,
   input wire ready_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   a_rst_low: assert property (sensor_rst_oe_o |-> !sensor_rst_b_o)
      else $error("sensor reset not driven low");
   a_rst_free: assert property (ready_o |-> !sensor_rst_oe_o)
      else $error("sensor reset held while bridging");
   a_test_end: assert property ($fell(sensor_rst_oe_o) |-> ##[0:2] (ready_o || test_mode_o))
      else $error("no mode after self test");
   a_mode_excl: assert property (!(ready_o && test_mode_o))
      else $error("test and bridge modes together");
   a_ready_keep: assert property (ready_o |=> ready_o)
      else $error("ready dropped");
   a_tx_quiet: assert property (sensor_rst_oe_o |-> sensor_tx_o)
      else $error("line active in self test");
   // Bit time is at least 8 clocks for every divider used here
   a_bit_hold: assert property ($fell(sensor_tx_o) |-> !sensor_tx_o [*8])
      else $error("low bit too short");
   a_rd_idle: assert property (rd_b_i [*8] |=> !rdata_oe_o)
      else $error("read drive without strobe");
   c_ready: cover property (ready_o);
   c_test: cover property (test_mode_o);
   c_read: cover property ($rose(rdata_oe_o));
endmodule

// ---- testbench/sensor_model.sv ----
// Sensor end of the serial link
`timescale 1ns/10ps
module sensor_model #(
   parameter DIV = 16
) (
   input wire ref_clk_i,
   input wire tx_i,
   input wire rst_line_i,
   output reg rx_o
);
   reg [7:0] got = 8'h00;
   reg stop_ok = 1'b0;
   integer got_n = 0;
   integer i;
   initial rx_o = 1'b1;
   // Mid-bit sampling, LSB first, 8N1
   always begin
      @(negedge tx_i);
      repeat (DIV / 2) @(posedge ref_clk_i);
      for (i = 0; i < 8; i = i + 1) begin
         repeat (DIV) @(posedge ref_clk_i);
         got[i] = tx_i;
      end
      repeat (DIV) @(posedge ref_clk_i);
      stop_ok = tx_i;
      got_n = got_n + 1;
   end
   // A sensor still in reset stays silent
   task send(input [7:0] b);
      integer j;
      begin
         if (rst_line_i === 1'b1) begin
            for (j = 0; j < 10; j = j + 1) begin
               @(posedge ref_clk_i);
               rx_o <= (j == 0) ? 1'b0 : (j == 9) ? 1'b1 : b[j - 1];
               repeat (DIV - 1) @(posedge ref_clk_i);
            end
         end
      end
   endtask
endmodule

// ---- testbench/test_gas_bridge_module.sv ----
// Testbench for the gas sensor serial bridge
`timescale 1ns/10ps
module test_gas_bridge_module;
   localparam DIV = 16;
   localparam ST = 20;
   reg ref_clk_i = 1'b0;
   reg rst_b_i = 1'b0;
   reg [9:0] addr_i = 10'h300;
   reg cs_b_i = 1'b1;
   reg wr_b_i = 1'b1;
   reg rd_b_i = 1'b1;
   reg [7:0] wdata_i = 8'h00;
   reg test_b = 1'b1;
   reg spare_b = 1'b0;
   wire [7:0] rdata_o;
   wire rdata_oe_o, tx, rx, rst_b_o, rst_oe, test_mode_o, ready_o;
   // Open-collector wire with pull-up
   wire rst_line = (rst_oe && !rst_b_o) ? 1'b0 : 1'b1;
   integer errors = 0;
   integer cmp_count = 0;
   integer k;
   reg [7:0] rd;
   reg ok;
   always #12.5 ref_clk_i = ~ref_clk_i;
   gas_bridge_module #(.BAUD_DIV(DIV), .SELFTEST_CYC(ST)) dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .addr_i(addr_i), .cs_b_i(cs_b_i), .wr_b_i(wr_b_i), .rd_b_i(rd_b_i), .wdata_i(wdata_i),
      .rdata_o(rdata_o), .rdata_oe_o(rdata_oe_o), .sensor_rx_i(rx), .sensor_tx_o(tx),
      .sensor_rst_b_i(rst_line), .sensor_rst_b_o(rst_b_o), .sensor_rst_oe_o(rst_oe),
      .test_mode_jumper_b_i(test_b), .spare_option_jumper_b_i(spare_b), .test_mode_o(test_mode_o),
      .ready_o(ready_o));
   sensor_model #(.DIV(DIV)) sensor (.ref_clk_i(ref_clk_i), .tx_i(tx), .rst_line_i(rst_line), .rx_o(rx));
   task chk(input [7:0] got, input [7:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task summarize;
      begin
         if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // Strobes are held long enough for the three-stage synchroniser
   task access(input [9:0] a, input wr, input [7:0] d);
      begin
         @(posedge ref_clk_i);
         addr_i <= a;
         wdata_i <= d;
         cs_b_i <= 1'b0;
         wr_b_i <= !wr;
         rd_b_i <= wr;
         ok = 1'b0;
         for (k = 0; k < 12 && !ok; k = k + 1) begin
            @(posedge ref_clk_i);
            ok = (rdata_oe_o === 1'b1);
         end
         rd = rdata_o;
         cs_b_i <= 1'b1;
         wr_b_i <= 1'b1;
         rd_b_i <= 1'b1;
         repeat (6) @(posedge ref_clk_i);
      end
   endtask
   initial begin
      #2000000;
      errors = errors + 1;
      summarize;
   end
   initial begin
      repeat (4) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      repeat (ST - 5) @(posedge ref_clk_i);
      chk({rst_line, ready_o}, 8'h00);
      for (k = 0; k < 40 && ready_o !== 1'b1; k = k + 1) @(posedge ref_clk_i);
      chk({rst_line, ready_o, test_mode_o}, 8'h06);
      access(10'h301, 0, 8'h00);
      chk({3'h0, rd[4:0]}, 8'h06);
      access(10'h300, 1, 8'hA5);
      access(10'h200, 1, 8'h3C);
      for (k = 0; k < 400 && sensor.got_n == 0; k = k + 1) @(posedge ref_clk_i);
      repeat (300) @(posedge ref_clk_i);
      chk(sensor.got_n, 8'h01);
      chk(sensor.got, 8'hA5);
      chk(sensor.stop_ok, 8'h01);
      access(10'h201, 0, 8'h00);
      chk(ok, 8'h00);
      sensor.send(8'h3C);
      repeat (DIV) @(posedge ref_clk_i);
      access(10'h301, 0, 8'h00);
      chk(rd[0], 8'h01);
      access(10'h300, 0, 8'h00);
      chk(rd, 8'h3C);
      access(10'h301, 0, 8'h00);
      chk(rd[0], 8'h00);
      sensor.send(8'h11);
      sensor.send(8'h22);
      repeat (DIV) @(posedge ref_clk_i);
      access(10'h301, 0, 8'h00);
      chk({3'h0, rd[4:0] & 5'h11}, 8'h11);
      access(10'h301, 1, 8'h10);
      access(10'h301, 0, 8'h00);
      chk(rd[4], 8'h00);
      access(10'h300, 0, 8'h00);
      chk(rd, 8'h22);
      rst_b_i <= 1'b0;
      test_b <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      for (k = 0; k < 40 && test_mode_o !== 1'b1; k = k + 1) @(posedge ref_clk_i);
      chk({test_mode_o, ready_o}, 8'h02);
      summarize;
   end
endmodule
bind gas_bridge_module bridge_checker port_check (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .rd_b_i(rd_b_i),
   .rdata_oe_o(rdata_oe_o), .sensor_tx_o(sensor_tx_o), .sensor_rst_b_o(sensor_rst_b_o),
   .sensor_rst_oe_o(sensor_rst_oe_o), .test_mode_o(test_mode_o), .ready_o(ready_o));
